/* File: src/gpib_aux_command_decoder.sv */
// Auxiliary command decoder of the talker/listener/controller.
// Assumes the register port strobe i_write is a one-cycle pulse on i_clock;
// i_ext_reset comes from a pin and is synchronised here.
`timescale 1ns/1ns
`default_nettype none

// Overview of operation
// - Control code zero: low five bits select and run a special function.
// - Nonzero control code loads command bits into the selected hidden reg.
// - Command identified by full byte; control bits zero, byte equals code.
// - 03 finish handshake, 04 trigger, 05 return to local, 06 send EOI.
// - 07 invalid secondary, 0F valid secondary command or address.
// - 01 clears parallel poll flag, 09 sets it.
// - 11 take control async pulse, 12 sync, 1A sync on end.
// - 10 standby, 13 listen, 1B continuous listen, 1C local unlisten.
// - Command 00 raises local power-on, holding interface functions idle.
// - Command 00 while power-on active drops power-on, releasing idle hold.
// - Command 02 resets like the external pulse, setting power-on.
// - Chip reset clears system controller, serial poll register, EOI bit.
// - Chip reset clears hidden registers A, B and E.
// - Chip reset clears parallel poll flag and request system control.
// - Chip reset loads internal counter with eight.
// - Chip reset clears both pin role select bits.
// - Control code is bits seven to five and selects hidden register.
// - Valid secondary releases held data-accepted, acts as own secondary.
module gpib_aux_command_decoder (
  input wire logic i_clock,
  input wire logic i_arst_n,
  input wire logic i_write,
  input wire logic [7:0] i_write_data,
  input wire logic i_ext_reset,
  input wire logic [2:0] i_hidden_sel,
  input wire logic i_sys_ctrl_set,
  input wire logic i_spoll_write,
  input wire logic [7:0] i_spoll_data,
  input wire logic i_rsc_set,
  input wire logic i_pin_role_write,
  input wire logic [1:0] i_pin_role_data,
  output logic o_power_on,
  output logic o_finish_handshake,
  output logic o_trigger,
  output logic o_return_to_local,
  output logic o_send_eoi,
  output logic o_invalid_secondary,
  output logic o_valid_secondary,
  output logic o_dac_release,
  output logic o_parallel_poll_flag,
  output logic o_take_control_async,
  output logic o_take_control_sync,
  output logic o_take_control_sync_end,
  output logic o_go_to_standby,
  output logic o_listen,
  output logic o_listen_continuous,
  output logic o_local_unlisten,
  output logic o_system_controller,
  output logic [7:0] o_serial_poll_response_register,
  output logic o_eoi_bit,
  output logic o_request_system_control,
  output logic [3:0] o_internal_counter_register,
  output logic o_pin_role_select_0,
  output logic o_pin_role_select_1,
  output logic [4:0] o_hidden_data
);

  typedef enum logic [1:0] {
    PON_RUN = 2'h0,
    PON_HELD = 2'h1
  } pon_state_t;

  pon_state_t pon_state;
  pon_state_t next_pon_state;
  logic ext_meta;
  logic ext_sync;
  logic ext_prev;
  logic ext_pulse;
  logic [2:0] ctrl_code;
  logic [4:0] cmd_code;
  logic special;
  logic chip_reset;
  logic hidden_clear;

  assign ctrl_code = i_write_data[aux_cmd_pkg::CTRL_MSB:aux_cmd_pkg::CTRL_LSB];
  assign cmd_code = i_write_data[aux_cmd_pkg::CMD_MSB:aux_cmd_pkg::CMD_LSB];
  // Special function only on an all-zero control code
  assign special = i_write && (ctrl_code == aux_cmd_pkg::CTRL_SPECIAL);
  // External pulse and command 02 share one reset path
  assign chip_reset = special && (cmd_code == aux_cmd_pkg::CMD_CHIP_RESET);
  assign ext_pulse = ext_sync && !ext_prev;
  assign hidden_clear = chip_reset || ext_pulse;

  // Pin synchroniser; the second stage and its delayed copy are looked at
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ext_meta <= 1'b0;
      ext_sync <= 1'b0;
      ext_prev <= 1'b0;
    end else begin
      ext_meta <= i_ext_reset;
      ext_sync <= ext_meta;
      ext_prev <= ext_sync;
    end
  end

  // Power-on hold: 00 toggles it, reset sets it
  always_comb begin
    next_pon_state = pon_state;
    if (ext_pulse || chip_reset) begin
      next_pon_state = PON_HELD;
    end else if (special && cmd_code == aux_cmd_pkg::CMD_PON) begin
      next_pon_state = (pon_state == PON_HELD) ? PON_RUN : PON_HELD;
    end
  end

  // A reset pin holds power-on from the start
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pon_state <= PON_HELD;
      o_power_on <= 1'b1;
    end else begin
      pon_state <= next_pon_state;
      o_power_on <= (next_pon_state == PON_HELD);
    end
  end

  // One-cycle command pulses; unlisted codes hit no case
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_finish_handshake <= 1'b0;
      o_trigger <= 1'b0;
      o_return_to_local <= 1'b0;
      o_send_eoi <= 1'b0;
      o_invalid_secondary <= 1'b0;
      o_valid_secondary <= 1'b0;
      o_dac_release <= 1'b0;
    end else begin
      o_finish_handshake <= special && cmd_code == aux_cmd_pkg::CMD_FINISH_HS;
      o_trigger <= special && cmd_code == aux_cmd_pkg::CMD_TRIGGER;
      o_return_to_local <= special && cmd_code == aux_cmd_pkg::CMD_RTL;
      o_send_eoi <= special && cmd_code == aux_cmd_pkg::CMD_SEND_EOI;
      o_invalid_secondary <= special &&
                             cmd_code == aux_cmd_pkg::CMD_INVALID_SEC;
      o_valid_secondary <= special && cmd_code == aux_cmd_pkg::CMD_VALID_SEC;
      // Either secondary verdict frees the held handshake
      o_dac_release <= special && (cmd_code == aux_cmd_pkg::CMD_VALID_SEC ||
                       cmd_code == aux_cmd_pkg::CMD_INVALID_SEC);
    end
  end

  // Controller and listener command pulses
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_take_control_async <= 1'b0;
      o_take_control_sync <= 1'b0;
      o_take_control_sync_end <= 1'b0;
      o_go_to_standby <= 1'b0;
      o_listen <= 1'b0;
      o_listen_continuous <= 1'b0;
      o_local_unlisten <= 1'b0;
    end else begin
      o_take_control_async <= special && cmd_code == aux_cmd_pkg::CMD_TCA;
      o_take_control_sync <= special && cmd_code == aux_cmd_pkg::CMD_TCS;
      o_take_control_sync_end <= special &&
                                 cmd_code == aux_cmd_pkg::CMD_TCS_END;
      o_go_to_standby <= special && cmd_code == aux_cmd_pkg::CMD_STANDBY;
      o_listen <= special && cmd_code == aux_cmd_pkg::CMD_LISTEN;
      o_listen_continuous <= special &&
                             cmd_code == aux_cmd_pkg::CMD_LISTEN_CONT;
      o_local_unlisten <= special && cmd_code == aux_cmd_pkg::CMD_LOCAL_UNL;
    end
  end

  // Parallel poll flag follows bit three of its commands
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_parallel_poll_flag <= 1'b0;
    end else if (hidden_clear) begin
      o_parallel_poll_flag <= 1'b0;
    end else if (special && cmd_code == aux_cmd_pkg::CMD_SET_PP) begin
      o_parallel_poll_flag <= 1'b1;
    end else if (special && cmd_code == aux_cmd_pkg::CMD_CLR_PP) begin
      o_parallel_poll_flag <= 1'b0;
    end
  end

  // Bits held elsewhere in the chip; reset clears them
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_system_controller <= 1'b0;
      o_serial_poll_response_register <= aux_cmd_pkg::SPOLL_RESET;
      o_eoi_bit <= 1'b0;
      o_request_system_control <= 1'b0;
      o_pin_role_select_0 <= 1'b0;
      o_pin_role_select_1 <= 1'b0;
    end else if (hidden_clear) begin
      o_system_controller <= 1'b0;
      o_serial_poll_response_register <= aux_cmd_pkg::SPOLL_RESET;
      o_eoi_bit <= 1'b0;
      o_request_system_control <= 1'b0;
      o_pin_role_select_0 <= 1'b0;
      o_pin_role_select_1 <= 1'b0;
    end else begin
      if (i_sys_ctrl_set) begin
        o_system_controller <= 1'b1;
      end
      if (i_spoll_write) begin
        o_serial_poll_response_register <= i_spoll_data;
      end
      if (special && cmd_code == aux_cmd_pkg::CMD_SEND_EOI) begin
        o_eoi_bit <= 1'b1;
      end
      if (i_rsc_set) begin
        o_request_system_control <= 1'b1;
      end
      if (i_pin_role_write) begin
        o_pin_role_select_0 <= i_pin_role_data[0];
        o_pin_role_select_1 <= i_pin_role_data[1];
      end
    end
  end

  // Internal counter goes to eight on reset
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_internal_counter_register <= aux_cmd_pkg::COUNTER_RESET;
    end else if (hidden_clear) begin
      o_internal_counter_register <= aux_cmd_pkg::COUNTER_RESET;
    end
  end

  // Every hidden slot, A, B and E among them, clears on reset
  hidden_reg_bank u_hidden (
    .i_clock(i_clock),
    .i_arst_n(i_arst_n),
    .i_clear(hidden_clear),
    .i_write(i_write && ctrl_code != aux_cmd_pkg::CTRL_SPECIAL),
    .i_write_sel(ctrl_code),
    .i_write_data(cmd_code),
    .i_read_sel(i_hidden_sel),
    .o_read_data(o_hidden_data)
  );

  sequence s_pon_write;
    special && cmd_code == aux_cmd_pkg::CMD_PON && !ext_pulse;
  endsequence

  a_trigger_pulse: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (i_write && i_write_data == 8'h04) |=> o_trigger ##1 !o_trigger)
    else $error("trigger pulse wrong");
  a_pon_release: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (s_pon_write and o_power_on) |=> !o_power_on)
    else $error("power on not released");
  a_pon_raise: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (s_pon_write and !o_power_on) |=> o_power_on)
    else $error("power on not raised");
  a_reset_pon: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    chip_reset |=> o_power_on && !o_parallel_poll_flag)
    else $error("chip reset ineffective");
  a_counter_eight: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    chip_reset |=> o_internal_counter_register == 4'h8)
    else $error("counter not eight");
  a_reset_bits: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    chip_reset |=> !o_system_controller && !o_eoi_bit &&
    o_serial_poll_response_register == 8'h00)
    else $error("reset bits not cleared");
  a_pin_roles: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    chip_reset |=> !o_pin_role_select_0 && !o_pin_role_select_1)
    else $error("pin roles not cleared");
  a_pp_set: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (i_write && i_write_data == 8'h09 && !ext_pulse) |=>
    o_parallel_poll_flag)
    else $error("parallel poll flag not set");
  a_no_special: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (i_write && ctrl_code != 3'h0 && !ext_pulse) |=> !o_listen && !o_trigger &&
    $stable(o_power_on))
    else $error("hidden write ran a function");
  a_valid_dac: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (i_write && i_write_data == 8'h0F) |=> o_valid_secondary &&
    o_dac_release)
    else $error("valid secondary missing");

endmodule : gpib_aux_command_decoder
`default_nettype wire

/* File: src/aux_cmd_pkg.sv */
// Package for the auxiliary command decoder: command codes, control codes,
// field positions and reset values.
// Assumes a single device clock domain; no other file state is shared.
package aux_cmd_pkg;

  // Field positions inside the command byte
  localparam int CTRL_MSB = 7;
  localparam int CTRL_LSB = 5;
  localparam int CMD_MSB = 4;
  localparam int CMD_LSB = 0;

  // Control codes
  localparam logic [2:0] CTRL_SPECIAL = 3'h0;

  // Hidden register slots, indexed by control code
  localparam int HIDDEN_SLOTS = 8;

  // Special function command codes
  localparam logic [4:0] CMD_PON = 5'h00;
  localparam logic [4:0] CMD_CLR_PP = 5'h01;
  localparam logic [4:0] CMD_CHIP_RESET = 5'h02;
  localparam logic [4:0] CMD_FINISH_HS = 5'h03;
  localparam logic [4:0] CMD_TRIGGER = 5'h04;
  localparam logic [4:0] CMD_RTL = 5'h05;
  localparam logic [4:0] CMD_SEND_EOI = 5'h06;
  localparam logic [4:0] CMD_INVALID_SEC = 5'h07;
  localparam logic [4:0] CMD_SET_PP = 5'h09;
  localparam logic [4:0] CMD_VALID_SEC = 5'h0F;
  localparam logic [4:0] CMD_STANDBY = 5'h10;
  localparam logic [4:0] CMD_TCA = 5'h11;
  localparam logic [4:0] CMD_TCS = 5'h12;
  localparam logic [4:0] CMD_LISTEN = 5'h13;
  localparam logic [4:0] CMD_TCS_END = 5'h1A;
  localparam logic [4:0] CMD_LISTEN_CONT = 5'h1B;
  localparam logic [4:0] CMD_LOCAL_UNL = 5'h1C;

  // Reset values
  localparam logic [4:0] HIDDEN_RESET = 5'h00;
  localparam logic [3:0] COUNTER_RESET = 4'h8;
  localparam logic [7:0] SPOLL_RESET = 8'h00;

endpackage : aux_cmd_pkg

/* File: src/hidden_reg_bank.sv */
// Bank of five-bit hidden registers addressed by the control code.
// Assumes writes come from the decoder on the same clock; read data is
// registered, so a read shows the value one cycle after the address.
`timescale 1ns/1ns
`default_nettype none
module hidden_reg_bank (
  input wire logic i_clock,
  input wire logic i_arst_n,
  input wire logic i_clear,
  input wire logic i_write,
  input wire logic [2:0] i_write_sel,
  input wire logic [4:0] i_write_data,
  input wire logic [2:0] i_read_sel,
  output logic [4:0] o_read_data
);

  logic [4:0] slot [aux_cmd_pkg::HIDDEN_SLOTS];

  // One storage word per control code; clear wins over a write
  genvar g;
  generate
    for (g = 0; g < aux_cmd_pkg::HIDDEN_SLOTS; g++) begin : g_slot
      always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
          slot[g] <= aux_cmd_pkg::HIDDEN_RESET;
        end else if (i_clear) begin
          slot[g] <= aux_cmd_pkg::HIDDEN_RESET;
        end else if (i_write && i_write_sel == 3'(g)) begin
          slot[g] <= i_write_data;
        end
      end
    end
  endgenerate

  // Registered read port
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_read_data <= aux_cmd_pkg::HIDDEN_RESET;
    end else begin
      o_read_data <= slot[i_read_sel];
    end
  end

endmodule : hidden_reg_bank
`default_nettype wire

/* File: dv/host_port_model.sv */
// Host side model: issues byte writes to the command register.
// Assumes callers start a write just after a rising clock edge.
`timescale 1ns/1ns
`default_nettype none
module host_port_model (
  input wire logic i_clock,
  output logic o_write,
  output logic [7:0] o_data
);
  // Idle bus starts with a pattern, never a clean zero
  initial begin
    o_write = 1'b0;
    o_data = 8'hA5;
  end

  // Whole byte held through the sampling edge
  task automatic write_byte(input logic [7:0] value);
    // Let one idle edge pass first, so a strobe just lowered by the last
    // write is never raised again in the same time step
    @(posedge i_clock);
    #10;
    o_write = 1'b1;
    o_data = value;
    @(posedge i_clock);
    #10;
    o_write = 1'b0;
    o_data = ~value; // Released bus must not keep the last value
  endtask : write_byte
endmodule : host_port_model
`default_nettype wire

/* File: dv/gpib_aux_command_decoder_tb.sv */
// Self-checking bench of the auxiliary command decoder.
// Assumes one 10 MHz clock; inputs change 10 ns after each rising edge.
`timescale 1ns/1ns
`default_nettype none
module gpib_aux_command_decoder_tb;
  logic i_clock, i_arst_n, i_ext_reset, i_sys_ctrl_set, i_spoll_write;
  logic i_rsc_set, i_pin_role_write, wr;
  logic [7:0] wdata, i_spoll_data;
  logic [2:0] i_hidden_sel;
  logic [1:0] i_pin_role_data;
  logic o_power_on, o_fh, o_trig, o_rtl, o_seoi, o_inv, o_val, o_dac;
  logic o_pp, o_tca, o_tcs, o_tcse, o_stby, o_lsn, o_lsnc, o_unl;
  logic o_sysc, o_eoi, o_rsc, o_pr0, o_pr1;
  logic [7:0] o_spoll;
  logic [3:0] o_cnt;
  logic [4:0] o_hid;
  logic [13:0] pulses;
  int miscompares = 0;
  int checked = 0;
  localparam logic [4:0] CODES [13] = '{5'h03, 5'h04, 5'h05, 5'h06,
    5'h07, 5'h0F, 5'h11, 5'h12, 5'h1A, 5'h10, 5'h13, 5'h1B, 5'h1C};

  // Pulse outputs in the same order as CODES, release strobe last
  assign pulses = {o_fh, o_trig, o_rtl, o_seoi, o_inv, o_val, o_tca, o_tcs,
    o_tcse, o_stby, o_lsn, o_lsnc, o_unl, o_dac};

  host_port_model host (.i_clock(i_clock), .o_write(wr), .o_data(wdata));

  gpib_aux_command_decoder DUT (
    .i_clock(i_clock), .i_arst_n(i_arst_n), .i_write(wr),
    .i_write_data(wdata), .i_ext_reset(i_ext_reset),
    .i_hidden_sel(i_hidden_sel), .i_sys_ctrl_set(i_sys_ctrl_set),
    .i_spoll_write(i_spoll_write), .i_spoll_data(i_spoll_data),
    .i_rsc_set(i_rsc_set), .i_pin_role_write(i_pin_role_write),
    .i_pin_role_data(i_pin_role_data), .o_power_on(o_power_on),
    .o_finish_handshake(o_fh), .o_trigger(o_trig),
    .o_return_to_local(o_rtl), .o_send_eoi(o_seoi),
    .o_invalid_secondary(o_inv), .o_valid_secondary(o_val),
    .o_dac_release(o_dac), .o_parallel_poll_flag(o_pp),
    .o_take_control_async(o_tca), .o_take_control_sync(o_tcs),
    .o_take_control_sync_end(o_tcse), .o_go_to_standby(o_stby),
    .o_listen(o_lsn), .o_listen_continuous(o_lsnc),
    .o_local_unlisten(o_unl), .o_system_controller(o_sysc),
    .o_serial_poll_response_register(o_spoll), .o_eoi_bit(o_eoi),
    .o_request_system_control(o_rsc), .o_internal_counter_register(o_cnt),
    .o_pin_role_select_0(o_pr0), .o_pin_role_select_1(o_pr1),
    .o_hidden_data(o_hid));

  // Free-running device clock
  initial begin
    i_clock = 1'b0;
    forever #50 i_clock = ~i_clock;
  end

  task automatic cyc;
    @(posedge i_clock);
    #10;
  endtask : cyc

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic finish_test;
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : finish_test

  // Every reset source must leave the same idle picture
  task automatic t_reset_state;
    int s;
    chk(o_power_on, 1'b1);
    chk(o_cnt, 4'h8);
    chk({o_sysc, o_spoll, o_eoi}, 10'h000);
    chk({o_pp, o_rsc}, 2'h0);
    chk({o_pr1, o_pr0}, 2'h0);
    for (s = 1; s < 8; s++) begin
      i_hidden_sel = s[2:0];
      cyc();
      chk(o_hid, 5'h00);
    end
    $display("test reset_state done");
  endtask : t_reset_state

  // Repeated 00 flips the local power-on message
  task automatic t_pon;
    host.write_byte(8'h00);
    chk(o_power_on, 1'b0);
    host.write_byte(8'h00);
    chk(o_power_on, 1'b1);
    host.write_byte(8'h00);
    chk(o_power_on, 1'b0);
    $display("test pon done");
  endtask : t_pon

  // Each pulse command, back to back, fires only its own output; 07 and 0F also fire the release strobe
  task automatic t_pulses;
    int i;
    logic [13:0] exp;
    for (i = 0; i < 13; i++) begin
      host.write_byte({3'h0, CODES[i]});
      exp = {13'h1000 >> i, i == 4 || i == 5};
      chk(pulses, exp);
    end
    cyc();
    chk(pulses, 14'h0000);
    $display("test pulses done");
  endtask : t_pulses

  // Flag set and clear; an unlisted code must disturb nothing
  task automatic t_pp;
    host.write_byte(8'h09);
    chk(o_pp, 1'b1);
    host.write_byte(8'h01);
    chk(o_pp, 1'b0);
    host.write_byte(8'h09);
    host.write_byte(8'h08);
    chk({o_pp, o_power_on, pulses}, 16'h8000);
    $display("test pp done");
  endtask : t_pp

  // Nonzero control code stores the low bits and runs nothing
  task automatic t_hidden;
    int s;
    for (s = 1; s < 8; s++) begin
      host.write_byte({s[2:0], 5'h04 ^ 5'(s)});
      chk(pulses, 14'h0000);
    end
    for (s = 1; s < 8; s++) begin
      i_hidden_sel = s[2:0];
      cyc();
      chk(o_hid, 5'h04 ^ 5'(s));
    end
    $display("test hidden done");
  endtask : t_hidden

  // Bring every level that reset must clear, save pin role bit 0 and hidden slots 2 to 7, to a
  // nonzero value; each set input and each pin role bit goes on its own, so a crossed wire shows
  task automatic load_levels;
    i_sys_ctrl_set = 1'b1;
    cyc();
    i_sys_ctrl_set = 1'b0;
    i_rsc_set = 1'b1;
    cyc();
    i_rsc_set = 1'b0;
    chk({o_sysc, o_rsc, o_spoll}, 10'h300);
    i_spoll_write = 1'b1;
    i_spoll_data = 8'h5A;
    i_pin_role_write = 1'b1;
    i_pin_role_data = 2'h1;
    cyc();
    chk({o_spoll, o_pr1, o_pr0}, 10'h169);
    i_spoll_data = 8'hC3;
    i_pin_role_data = 2'h2;
    cyc();
    i_spoll_write = 1'b0;
    i_pin_role_write = 1'b0;
    chk({o_spoll, o_pr1, o_pr0}, 10'h30E);
    host.write_byte(8'h06);
    host.write_byte(8'h09);
    host.write_byte(8'h3F);
    chk({o_sysc, o_eoi, o_rsc, o_pp}, 4'hF);
  endtask : load_levels

  task automatic t_chip_reset;
    load_levels();
    host.write_byte(8'h02);
    t_reset_state();
    $display("test chip_reset done");
  endtask : t_chip_reset

  // Pin reset passes a two-stage synchroniser before acting
  task automatic t_ext_reset;
    host.write_byte(8'h00);
    chk(o_power_on, 1'b0);
    load_levels();
    i_ext_reset = 1'b1;
    repeat (2) cyc();
    i_ext_reset = 1'b0;
    repeat (4) cyc();
    t_reset_state();
    host.write_byte(8'h00);
    chk(o_power_on, 1'b0);
    $display("test ext_reset done");
  endtask : t_ext_reset

  // Main sequence
  initial begin
    i_arst_n = 1'b0;
    i_ext_reset = 1'b0;
    i_sys_ctrl_set = 1'b0;
    i_spoll_write = 1'b0;
    i_rsc_set = 1'b0;
    i_pin_role_write = 1'b0;
    i_spoll_data = 8'h00;
    i_pin_role_data = 2'h0;
    i_hidden_sel = 3'h1;
    repeat (2) @(posedge i_clock);
    #10;
    i_arst_n = 1'b1;
    t_reset_state();
    t_pon();
    t_pulses();
    t_pp();
    t_hidden();
    t_chip_reset();
    t_ext_reset();
    finish_test();
  end

  // Hang guard
  initial begin
    #1000000;
    miscompares++;
    finish_test();
  end
endmodule : gpib_aux_command_decoder_tb
`default_nettype wire
